// ===== hw/apms_sequencer.sv
// Power mode sequencer for a sampling ADC
`timescale 1ns/10ps
`include "apms_regs.svh"
module apms_sequencer
    import apms_pkg::*;
#(
    parameter int POR_TIMEOUT_CYC = `APMS_POR_TIMEOUT_CYC,
    parameter int POR_CAL_CYC = `APMS_POR_CAL_CYC
)
(
    input wire logic CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic CONVERT_START_STROBE_IN,
    input wire logic CTRL_WRITE_IN,
    input wire logic POWER_MODE_HIGH_BIT_IN,
    input wire logic POWER_MODE_LOW_BIT_IN,
    output logic BUSY_OUT,
    output logic CORE_POWER_ON_OUT,
    output logic REF_POWER_ON_OUT,
    output logic CAL_ACTIVE_OUT,
    output logic CONV_DONE_OUT
);
    localparam logic [31:0] WAKE_CYC = 32'(`APMS_WAKE_CYC);
    localparam logic [31:0] CONV_CYC = 32'(`APMS_CONV_CYC);

    // ========================================================
    // Strobe edges and mode register
    apms_state_e state_r;
    apms_state_e state_nxt;
    apms_mode_e mode_r;
    apms_mode_e mode_nxt;
    logic strobe_d_r;
    logic busy_r;
    logic busy_nxt;
    logic core_r;
    logic core_nxt;
    logic ref_r;
    logic ref_nxt;
    logic cal_r;
    logic cal_nxt;
    logic done_r;
    logic done_nxt;
    logic tmr_load;
    logic [31:0] tmr_count;
    logic tmr_busy;
    logic tmr_done;
    logic strobe_rise;
    logic strobe_fall;
    logic [31:0] wake_cnt_r;
    logic [31:0] wake_cnt_nxt;

    assign strobe_rise = CONVERT_START_STROBE_IN && !strobe_d_r;
    assign strobe_fall = !CONVERT_START_STROBE_IN && strobe_d_r;

    always_comb
    begin
        mode_nxt = mode_r;
        if (CTRL_WRITE_IN)
        begin
            mode_nxt = apms_mode_e'({POWER_MODE_HIGH_BIT_IN, POWER_MODE_LOW_BIT_IN});
        end
    end

    apms_timer u_timer
    (
        .clk_in(CLK_IN),
        .arst_n_in(ARST_N_IN),
        .load_in(tmr_load),
        .count_in(tmr_count),
        .busy_out(tmr_busy),
        .done_out(tmr_done)
    );

    // ========================================================
    // Sequencer
    always_comb
    begin
        state_nxt = state_r;
        busy_nxt = busy_r;
        cal_nxt = 1'b0;
        done_nxt = 1'b0;
        tmr_load = 1'b0;
        tmr_count = 32'h0;
        unique case (state_r)
            ST_POR_IDLE:
            begin
                if (CTRL_WRITE_IN)
                begin
                    state_nxt = ST_IDLE;
                end
                else if (strobe_rise)
                begin
                    state_nxt = ST_POR_TIMEOUT;
                    busy_nxt = 1'b1;
                    tmr_load = 1'b1;
                    tmr_count = 32'(POR_TIMEOUT_CYC);
                end
            end
            ST_POR_TIMEOUT:
            begin
                if (tmr_done)
                begin
                    busy_nxt = 1'b0;
                    state_nxt = ST_POR_WAIT_CAL;
                end
            end
            ST_POR_WAIT_CAL:
            begin
                if (strobe_rise)
                begin
                    state_nxt = ST_POR_CAL;
                    busy_nxt = 1'b1;
                    cal_nxt = 1'b1;
                    tmr_load = 1'b1;
                    tmr_count = 32'(POR_CAL_CYC);
                end
            end
            ST_POR_CAL:
            begin
                cal_nxt = !tmr_done;
                if (tmr_done)
                begin
                    busy_nxt = 1'b0;
                    state_nxt = ST_IDLE;
                end
            end
            ST_IDLE:
            begin
                if (mode_r == APMS_MODE_FULL_PD)
                begin
                    state_nxt = ST_ASLEEP;
                end
                else if (strobe_rise)
                begin
                    state_nxt = ST_CONVERT;
                    busy_nxt = 1'b1;
                    tmr_load = 1'b1;
                    tmr_count = CONV_CYC;
                end
            end
            ST_ASLEEP:
            begin
                if (strobe_fall && mode_r != APMS_MODE_FULL_PD)
                begin
                    state_nxt = ST_WAKING;
                    tmr_load = 1'b1;
                    tmr_count = WAKE_CYC;
                end
                else if (mode_r == APMS_MODE_NORMAL)
                begin
                    state_nxt = ST_WAKING;
                    tmr_load = 1'b1;
                    tmr_count = WAKE_CYC;
                end
            end
            ST_WAKING:
            begin
                // Strobe rising early is lost: host holds it low long enough
                if (tmr_done)
                begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_CONVERT:
            begin
                if (tmr_done)
                begin
                    busy_nxt = 1'b0;
                    done_nxt = 1'b1;
                    if (mode_r == APMS_MODE_FULL_PD_AFTER || mode_r == APMS_MODE_PART_PD_AFTER
                        || mode_r == APMS_MODE_FULL_PD)
                    begin
                        state_nxt = ST_ASLEEP;
                    end
                    else
                    begin
                        state_nxt = ST_IDLE;
                    end
                end
            end
        endcase
    end

    // ========================================================
    // Power switches
    always_comb
    begin
        core_nxt = !(state_nxt == ST_ASLEEP);
        ref_nxt = !(state_nxt == ST_ASLEEP && mode_nxt != APMS_MODE_PART_PD_AFTER);
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            state_r <= ST_POR_IDLE;
            mode_r <= APMS_MODE_NORMAL;
            // Strobe idles high; matching it avoids a false edge
            strobe_d_r <= 1'b1;
            busy_r <= 1'b0;
            core_r <= 1'b1;
            ref_r <= 1'b1;
            cal_r <= 1'b0;
            done_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            mode_r <= mode_nxt;
            strobe_d_r <= CONVERT_START_STROBE_IN;
            busy_r <= busy_nxt;
            core_r <= core_nxt;
            ref_r <= ref_nxt;
            cal_r <= cal_nxt;
            done_r <= done_nxt;
        end
    end

    assign BUSY_OUT = busy_r;
    assign CORE_POWER_ON_OUT = core_r;
    assign REF_POWER_ON_OUT = ref_r;
    assign CAL_ACTIVE_OUT = cal_r;
    assign CONV_DONE_OUT = done_r;

    // ========================================================
    // Checks
    // Wake length counter, only read by the checks below
    always_comb
    begin
        wake_cnt_nxt = 32'h0;
        if (state_r == ST_WAKING)
        begin
            wake_cnt_nxt = wake_cnt_r + 32'h1;
        end
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            wake_cnt_r <= 32'h0;
        end
        else
        begin
            wake_cnt_r <= wake_cnt_nxt;
        end
    end

    chk_busy_done_fall: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        CONV_DONE_OUT |-> !BUSY_OUT && $past(BUSY_OUT))
        else $error("Conversion done without busy falling");
    chk_full_ref_off: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        (!CORE_POWER_ON_OUT && mode_r == APMS_MODE_FULL_PD && $stable(mode_r)) |-> !REF_POWER_ON_OUT)
        else $error("Reference on in full power-down");
    chk_part_ref_on: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        (mode_r == APMS_MODE_PART_PD_AFTER && $stable(mode_r)) |-> REF_POWER_ON_OUT)
        else $error("Reference off in partial power-down");
    chk_auto_sleep: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        (CONV_DONE_OUT && mode_r == APMS_MODE_FULL_PD_AFTER && $stable(mode_r)) |-> !CORE_POWER_ON_OUT)
        else $error("No power-down after conversion");
    chk_strobe_ignored: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        (state_r == ST_CONVERT && !tmr_done) |=> state_r == ST_CONVERT)
        else $error("Strobe taken while busy");
    chk_early_write: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        (state_r == ST_POR_IDLE && CTRL_WRITE_IN) |=> state_r == ST_IDLE && !BUSY_OUT)
        else $error("Early write did not cancel calibration");
    chk_cal_kept: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        (state_r == ST_POR_CAL && !tmr_done) |=> BUSY_OUT)
        else $error("Calibration aborted");
    chk_wake_time: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        (state_r == ST_ASLEEP && state_nxt == ST_WAKING) |=> state_r == ST_WAKING [*8])
        else $error("Wake shorter than expected");
    chk_first_strobe: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        (state_r == ST_POR_IDLE && strobe_rise && !CTRL_WRITE_IN) |=> BUSY_OUT && state_r == ST_POR_TIMEOUT)
        else $error("First strobe did not start timeout");
    chk_mode_decode: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        CTRL_WRITE_IN |=> mode_r[1] == $past(POWER_MODE_HIGH_BIT_IN) && mode_r[0] == $past(POWER_MODE_LOW_BIT_IN))
        else $error("Mode bits not decoded");
    chk_rise_converts: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        (state_r == ST_IDLE && strobe_rise && mode_r != APMS_MODE_FULL_PD) |=> BUSY_OUT && state_r == ST_CONVERT)
        else $error("Rising strobe did not start conversion");
    chk_soft_wake: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        (state_r == ST_ASLEEP && mode_r == APMS_MODE_NORMAL) |=> state_r == ST_WAKING && CORE_POWER_ON_OUT)
        else $error("Software power-up did not start wake");
    chk_wake_length: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        (state_r == ST_WAKING && state_nxt == ST_IDLE) |-> wake_cnt_r == WAKE_CYC)
        else $error("Wake time differs from the set length");
    chk_timer_running: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        (state_r == ST_CONVERT || state_r == ST_WAKING) |-> tmr_busy || tmr_done)
        else $error("Timed state without a running timer");
endmodule

// ===== hw/apms_regs.svh
// Timing counts and field positions for the ADC power mode sequencer
`ifndef APMS_REGS_SVH
`define APMS_REGS_SVH

`define APMS_CLK_MHZ 100
// Power management field bit positions
`define APMS_PM_LOW_BIT 0
`define APMS_PM_HIGH_BIT 1
`define APMS_PM_RESET 2'h0
// Power-on timeout and calibration, each half of the total (ms)
`define APMS_POR_TIMEOUT_MS 32
`define APMS_POR_CAL_MS 32
`define APMS_POR_TIMEOUT_CYC (`APMS_POR_TIMEOUT_MS * 1000 * `APMS_CLK_MHZ)
`define APMS_POR_CAL_CYC (`APMS_POR_CAL_MS * 1000 * `APMS_CLK_MHZ)
// Wake-up from full power-down (ns)
`define APMS_WAKE_NS 5000
`define APMS_WAKE_CYC ((`APMS_WAKE_NS * `APMS_CLK_MHZ + 999) / 1000)
// Conversion time (ns), standard variant
`define APMS_CONV_NS 4600
`define APMS_CONV_CYC ((`APMS_CONV_NS * `APMS_CLK_MHZ + 999) / 1000)

`endif

// ===== hw/apms_pkg.sv
// Types for the ADC power mode sequencer
package apms_pkg;
    typedef enum logic [1:0] {
        APMS_MODE_NORMAL,
        APMS_MODE_FULL_PD_AFTER,
        APMS_MODE_FULL_PD,
        APMS_MODE_PART_PD_AFTER
    } apms_mode_e;

    typedef enum {
        ST_POR_IDLE,
        ST_POR_TIMEOUT,
        ST_POR_WAIT_CAL,
        ST_POR_CAL,
        ST_IDLE,
        ST_ASLEEP,
        ST_WAKING,
        ST_CONVERT
    } apms_state_e;
endpackage

// ===== hw/apms_timer.sv
// Loadable down-counter with a done pulse
`timescale 1ns/10ps
module apms_timer
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic load_in,
    input wire logic [31:0] count_in,
    output logic busy_out,
    output logic done_out
);
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic done_r;
    logic done_nxt;

    always_comb
    begin
        cnt_nxt = cnt_r;
        done_nxt = 1'b0;
        if (load_in)
        begin
            cnt_nxt = count_in;
        end
        else if (cnt_r != 32'h0)
        begin
            cnt_nxt = cnt_r - 32'h1;
            done_nxt = (cnt_r == 32'h1);
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            cnt_r <= 32'h0;
            done_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign busy_out = (cnt_r != 32'h0);
    assign done_out = done_r;
endmodule

// ===== verification/apms_host_model.sv
// Host controller model: convert strobe and control writes
`timescale 1ns/10ps
module apms_host_model
#(
    parameter int LOW_CYC = 510
)
(
    input wire logic clk_in,
    output logic strobe_out,
    output logic write_out,
    output logic mode_high_out,
    output logic mode_low_out
);
    // ==========
    // Idle levels
    initial
    begin
        strobe_out = 1'b1;
        write_out = 1'b0;
        mode_high_out = 1'b1;
        mode_low_out = 1'b1;
    end

    // ==========
    // Strobe pulse, width zero means LOW_CYC (510 cycles, longer than the 500-cycle wake)
    // low width, one pulse per slot
    task automatic pulse(input int width);
        int w;
        w = (width == 0) ? LOW_CYC : width;
        @(posedge clk_in);
        strobe_out <= 1'b0;
        repeat (w) @(posedge clk_in);
        strobe_out <= 1'b1;
        @(posedge clk_in);
    endtask

    // ==========
    // Control write; bits are garbage outside the write cycle
    // host picks modes
    task automatic write_mode(input logic [1:0] mode);
        @(posedge clk_in);
        write_out <= 1'b1;
        mode_high_out <= mode[1];
        mode_low_out <= mode[0];
        @(posedge clk_in);
        write_out <= 1'b0;
        mode_high_out <= ~mode[1];
        mode_low_out <= ~mode[0];
    endtask
endmodule

// ===== verification/adc_power_mode_sequencer_tb_top.sv
// Self-checking bench for the ADC power mode sequencer
`timescale 1ns/10ps
`include "apms_regs.svh"
module adc_power_mode_sequencer_tb_top;
    localparam int TO = 50;
    localparam int CONV = `APMS_CONV_CYC;
    logic clk;
    logic arst_n;
    logic strobe;
    logic wr;
    logic m_hi;
    logic m_lo;
    logic busy;
    logic core;
    logic refp;
    logic cal;
    logic done;
    logic cal_seen;
    logic done_fall;
    int len;
    int bad_count = 0;
    int checked = 0;

    // ==========
    // Design and host
    apms_sequencer #(.POR_TIMEOUT_CYC(TO), .POR_CAL_CYC(TO)) dut_u
    (
        .CLK_IN(clk),
        .ARST_N_IN(arst_n),
        .CONVERT_START_STROBE_IN(strobe),
        .CTRL_WRITE_IN(wr),
        .POWER_MODE_HIGH_BIT_IN(m_hi),
        .POWER_MODE_LOW_BIT_IN(m_lo),
        .BUSY_OUT(busy),
        .CORE_POWER_ON_OUT(core),
        .REF_POWER_ON_OUT(refp),
        .CAL_ACTIVE_OUT(cal),
        .CONV_DONE_OUT(done)
    );
    apms_host_model host_u
    (
        .clk_in(clk),
        .strobe_out(strobe),
        .write_out(wr),
        .mode_high_out(m_hi),
        .mode_low_out(m_lo)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ==========
    // Shared tasks
    task automatic chk(input logic got, input logic exp, input string msg);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    task automatic chk_n(input int got, input int exp, input string msg);
        checked++;
        if (got != exp)
        begin
            bad_count++;
            $display("wrong value at %0t: %s got %0d", $time, msg, got);
        end
    endtask

    task automatic do_reset();
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
    endtask

    // Bounded wait for busy, then its length in cycles
    task automatic run_busy();
        int k;
        k = 0;
        len = 0;
        cal_seen = 1'b0;
        while (busy !== 1'b1 && k < 1000)
        begin
            @(posedge clk);
            #1;
            k++;
        end
        while (busy === 1'b1 && len < 5000)
        begin
            cal_seen = cal_seen | (cal === 1'b1);
            len++;
            @(posedge clk);
            #1;
        end
        done_fall = done;
    endtask

    task automatic run_conv();
        fork
            host_u.pulse(0);
            run_busy();
        join
        chk_n(len, CONV + 1, "conversion busy length");
        chk(done_fall, 1'b1, "done with busy fall");
    endtask

    // ==========
    // Scenarios
    task automatic t_por();
        fork
            host_u.pulse(3);
            run_busy();
        join
        chk_n(len, TO + 1, "timeout length");
        chk(cal_seen, 1'b0, "no calibration in timeout");
        fork
            host_u.pulse(3);
            run_busy();
            begin
                repeat (10) @(posedge clk);
                host_u.write_mode(2'h0);
            end
        join
        chk_n(len, TO + 1, "calibration not aborted");
        chk(cal_seen, 1'b1, "calibration ran");
        // Second strobe lands mid-conversion and must not restart it
        fork
            begin
                host_u.pulse(0);
                host_u.pulse(20);
            end
            run_busy();
        join
        chk_n(len, CONV + 1, "strobe while busy ignored");
    endtask

    task automatic t_cancel();
        do_reset();
        host_u.write_mode(2'h0);
        repeat (30000) @(posedge clk);
        fork
            host_u.pulse(0);
            run_busy();
        join
        chk_n(len, CONV + 1, "first strobe converts");
        chk(cal_seen, 1'b0, "calibration skipped");
    endtask

    task automatic t_modes();
        logic [1:0] m;
        for (int i = 0; i < 3; i++)
        begin
            m = (i == 0) ? 2'h0 : (i == 1) ? 2'h3 : 2'h1;
            host_u.write_mode(m);
            run_conv();
            repeat (2) @(posedge clk);
            #1;
            chk(core, m == 2'h0, "core power after conversion");
            chk(refp, m != 2'h1, "reference after conversion");
        end
    endtask

    task automatic t_wake();
        fork
            host_u.pulse(0);
            run_busy();
            begin
                repeat (3) @(posedge clk);
                #1;
                chk(core, 1'b1, "core wakes on strobe fall");
            end
        join
        chk_n(len, CONV + 1, "conversion after wake");
        fork
            host_u.pulse(20);
            run_busy();
        join
        chk_n(len, 0, "short strobe dropped");
    endtask

    task automatic t_perm();
        host_u.write_mode(2'h2);
        repeat (3) @(posedge clk);
        #1;
        chk(core, 1'b0, "core off in full power-down");
        chk(refp, 1'b0, "reference off in full power-down");
        fork
            host_u.pulse(0);
            run_busy();
        join
        chk_n(len, 0, "strobe ignored in full power-down");
        host_u.write_mode(2'h0);
        repeat (600) @(posedge clk);
        #1;
        chk(core, 1'b1, "software power-up");
        run_conv();
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ==========
    // Main sequence and watchdog
    initial
    begin
        arst_n = 1'b0;
        do_reset();
        t_por();
        t_cancel();
        t_modes();
        t_wake();
        t_perm();
        wrap_up();
    end

    initial
    begin
        #800000;
        bad_count++;
        wrap_up();
    end
endmodule
